// ===== fpc_pkg.sv
// package for the flash page-config host controller
package fpc_pkg;
  // ======================================================
  // register map of the controller (avalon word addresses)
  localparam logic [3:0]  FPC_CTRL_OFS      = 4'h0;
  localparam logic [3:0]  FPC_ADDR_OFS      = 4'h1;
  localparam logic [3:0]  FPC_WDATA_OFS     = 4'h2;
  localparam logic [3:0]  FPC_RDATA_OFS     = 4'h3;
  localparam logic [3:0]  FPC_STAT_OFS      = 4'h4;
  localparam logic [3:0]  FPC_PCFG_OFS      = 4'h5;
  // ======================================================
  // control command codes (ctrl bits 2:0)
  localparam logic [2:0]  FPC_OP_WRITE      = 3'h1;
  localparam logic [2:0]  FPC_OP_READ       = 3'h2;
  localparam logic [2:0]  FPC_OP_SETCFG     = 3'h3;
  localparam logic [2:0]  FPC_OP_RESET      = 3'h4;
  localparam int          FPC_CTRL_PROGRAM_VOLTAGE_PIN_BIT = 8;
  localparam int          FPC_CTRL_CS_LSB   = 9;
  // ======================================================
  // flash command data
  localparam logic [15:0] FPC_SETCFG_SETUP  = 16'h0060;
  localparam logic [15:0] FPC_SETCFG_CONF   = 16'h0004;
  localparam logic [15:0] FPC_CLR_STATUS    = 16'h0050;
  localparam logic [15:0] FPC_READ_ARRAY    = 16'h00ff;
  localparam int          FPC_PAGE_LEN_BIT  = 13;
  localparam logic [15:0] FPC_PCFG_RESET    = 16'h0000;
  // ======================================================
  // timing, 20 MHz clock
  localparam int          FPC_CLK_MHZ       = 20;
  localparam int          FPC_T_WE_NS       = 60;
  localparam int          FPC_T_OE_NS       = 100;
  localparam int          FPC_T_RST_NS      = 100;
  localparam int          FPC_T_REC_NS      = 210;
  localparam int          FPC_WE_CYC  = (FPC_T_WE_NS * FPC_CLK_MHZ + 999) / 1000;
  localparam int          FPC_OE_CYC  = (FPC_T_OE_NS * FPC_CLK_MHZ + 999) / 1000;
  localparam int          FPC_RST_CYC = (FPC_T_RST_NS * FPC_CLK_MHZ + 999) / 1000;
  localparam int          FPC_REC_CYC = (FPC_T_REC_NS * FPC_CLK_MHZ + 999) / 1000;
endpackage

// ===== fpc_host.sv
// host controller driving a parallel nor flash: commands, page config, reset
// Operation
// RL1: page config lost on reset or power
// RL2: set config: 0060h then 0004h, value on address
// RL3: device returns to array read afterwards
// RL4: bit 13 selects eight-word pages
// RL5: reserved config bits written as zero
// RL6: clear status after eight-word set command
// RL7: oe high floats device data; the flash model drives inverted data instead
// RL8: program clears bits, erase sets them
// RL9: erase acts on whole block
// RL10: program and erase need program voltage high
// RL11: any selected write is a command
// RL12: write latched on we rising edge
// RL13: deselect floats outputs, standby; the flash model drives inverted data instead
// RL14: engine continues while deselected
// RL15: reset low deselects, restores array read
// RL16: reset aborts running operation
// RL17: wait recovery after reset release
// RL18: flash reset follows system reset
// RL19: four-word pages after reset
// RL20: page word chosen by low address bits
// RL21: new length applies on next page load
// RL22: bad confirm leaves config unchanged
`timescale 1ns/100ps
module fpc_host import fpc_pkg::*; #(
  parameter int ADDR_W = 24
) (
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [3:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  output logic      [31:0]       avs_readdata_out,
  output logic                   avs_waitrequest_out,
  output logic      [ADDR_W-1:0] flash_addr_out,
  input  wire logic [15:0]       flash_data_in,
  output logic      [15:0]       flash_data_out,
  output logic                   flash_data_oe_out,
  output logic      [2:0]        chip_selects_out,
  output logic                   flash_oe_n_out,
  output logic                   flash_we_n_out,
  output logic                   powerdown_reset_n_out,
  output logic                   program_voltage_pin_out,
  input  wire logic              ready_busy_output_in
);
  // ======================================================
  // state
  typedef enum logic [6:0] {
    S_IDLE  = 7'b0000001,
    S_WE    = 7'b0000010,
    S_GAP   = 7'b0000100,
    S_OE    = 7'b0001000,
    S_RST   = 7'b0010000,
    S_REC   = 7'b0100000,
    S_ACK   = 7'b1000000
  } fpc_state_type;

  typedef struct packed {
    fpc_state_type     st;
    logic [7:0]        cnt;
    logic [1:0]        step;       // phase within a multi-write sequence
    logic              seq;        // set-config sequence active
    logic [ADDR_W-1:0] addr;
    logic [15:0]       wdata;
    logic [15:0]       rdata;
    logic [15:0]       pcfg;       // shadow of the device page config
    logic [8:0]        ctrl;
    logic [1:0]        rb_sync;
    logic              busy;
    logic [31:0]       rd;
    logic              wait_n;
    logic              wreq;       // registered waitrequest, high while not answering
    logic [ADDR_W-1:0] fa;
    logic [15:0]       fd;
    logic              fdoe;
    logic [2:0]        cs;
    logic              oe_n;
    logic              we_n;
    logic              rp_n;
  } fpc_regs_type;

  fpc_regs_type r_reg, r_next;

  // ======================================================
  // next-state logic
  always_comb begin
    r_next = r_reg;
    r_next.rb_sync = {r_reg.rb_sync[0], ready_busy_output_in};
    r_next.wait_n  = 1'b0;
    case (r_reg.st)
      S_IDLE: begin
        r_next.cs   = 3'h7;                    // deselected, standby [RL13]
        r_next.fdoe = 1'b0;
        r_next.oe_n = 1'b1;
        r_next.we_n = 1'b1;
        if (r_reg.seq) begin
          // next write of the set-config sequence
          r_next.st   = S_WE;
          r_next.cnt  = 8'(FPC_WE_CYC);
          r_next.cs   = 3'h0;
          r_next.we_n = 1'b0;
          r_next.fdoe = 1'b1;
          r_next.fa   = ADDR_W'(r_reg.pcfg);   // value on address lines [RL2]
          if (r_reg.step == 2'h0) begin
            r_next.fd = FPC_SETCFG_SETUP;      // [RL2]
          end else if (r_reg.step == 2'h1) begin
            r_next.fd = FPC_SETCFG_CONF;       // [RL2]
          end else begin
            r_next.fd = FPC_CLR_STATUS;        // [RL6]
          end
        end else if ((avs_write_in || avs_read_in) && !r_reg.wait_n) begin
          // decode the avalon access
          r_next.st = S_ACK;
          if (avs_read_in) begin
            if (avs_address_in == FPC_RDATA_OFS) begin
              r_next.rd = {16'h0000, r_reg.rdata};
            end else if (avs_address_in == FPC_STAT_OFS) begin
              r_next.rd = {30'h0, r_reg.rb_sync[1], r_reg.busy};
            end else if (avs_address_in == FPC_PCFG_OFS) begin
              r_next.rd = {16'h0000, r_reg.pcfg};
            end else if (avs_address_in == FPC_ADDR_OFS) begin
              r_next.rd = 32'(r_reg.addr);
            end else begin
              r_next.rd = 32'h0;
            end
          end else if (avs_address_in == FPC_ADDR_OFS) begin
            r_next.addr = avs_writedata_in[ADDR_W-1:0];
          end else if (avs_address_in == FPC_WDATA_OFS) begin
            r_next.wdata = avs_writedata_in[15:0];
          end else if (avs_address_in == FPC_CTRL_OFS) begin
            r_next.wait_n = 1'b1;               // ctrl answered at once, op runs behind it
            r_next.ctrl = avs_writedata_in[8:0];
            r_next.busy = 1'b1;
            r_next.fa   = r_reg.addr;
            r_next.cs   = 3'h0;
            case (avs_writedata_in[2:0])
              FPC_OP_WRITE: begin
                // any selected write is a command [RL11]
                r_next.st   = S_WE;
                r_next.cnt  = 8'(FPC_WE_CYC);
                r_next.we_n = 1'b0;
                r_next.fdoe = 1'b1;
                r_next.fd   = r_reg.wdata;
              end
              FPC_OP_READ: begin
                r_next.st   = S_OE;
                r_next.cnt  = 8'(FPC_OE_CYC);
                r_next.oe_n = 1'b0;
              end
              FPC_OP_SETCFG: begin
                // only bit 13 kept, reserved bits zero [RL5] [RL4]
                r_next.pcfg = {2'b00, r_reg.wdata[FPC_PAGE_LEN_BIT], 13'h0000};
                r_next.seq  = 1'b1;
                r_next.step = 2'h0;
                r_next.cs   = 3'h7;
                r_next.st   = S_IDLE;
              end
              FPC_OP_RESET: begin
                r_next.st   = S_RST;
                r_next.cnt  = 8'(FPC_RST_CYC);
                r_next.rp_n = 1'b0;             // aborts any operation [RL16]
                r_next.cs   = 3'h7;
              end
              default: begin
                r_next.busy = 1'b0;
                r_next.cs   = 3'h7;
                r_next.st   = S_IDLE;          // unknown op: nothing runs
              end
            endcase
          end
        end
      end
      S_WE: begin
        if (r_reg.cnt <= 8'h1) begin
          r_next.we_n = 1'b1;                  // device latches on this rise [RL12]
          r_next.st   = S_GAP;
        end else begin
          r_next.cnt = r_reg.cnt - 8'h1;
        end
      end
      S_GAP: begin
        r_next.cs   = 3'h7;                    // release chip select after we rise
        r_next.fdoe = 1'b0;
        r_next.st   = S_IDLE;
        if (r_reg.seq) begin
          if (r_reg.step == 2'h0) begin
            r_next.step = 2'h1;
          end else if (r_reg.step == 2'h1 && r_reg.pcfg[FPC_PAGE_LEN_BIT]) begin
            r_next.step = 2'h2;                // eight-word needs clear status [RL6]
          end else begin
            r_next.seq  = 1'b0;
            r_next.busy = 1'b0;
          end
        end else begin
          r_next.busy = 1'b0;
        end
      end
      S_OE: begin
        if (r_reg.cnt <= 8'h1) begin
          r_next.rdata = flash_data_in;
          r_next.oe_n  = 1'b1;
          r_next.cs    = 3'h7;
          r_next.busy  = 1'b0;
          r_next.st    = S_IDLE;
        end else begin
          r_next.cnt = r_reg.cnt - 8'h1;
        end
      end
      S_RST: begin
        if (r_reg.cnt <= 8'h1) begin
          r_next.rp_n = 1'b1;
          r_next.pcfg = FPC_PCFG_RESET;        // device config back to default [RL1] [RL19]
          r_next.st   = S_REC;
          r_next.cnt  = 8'(FPC_REC_CYC);
        end else begin
          r_next.cnt = r_reg.cnt - 8'h1;
        end
      end
      S_REC: begin
        if (r_reg.cnt <= 8'h1) begin
          r_next.busy = 1'b0;                  // recovery wait done [RL17]
          r_next.st   = S_IDLE;
        end else begin
          r_next.cnt = r_reg.cnt - 8'h1;
        end
      end
      S_ACK: begin
        r_next.wait_n = 1'b1;
        r_next.st     = S_IDLE;
      end
      default: r_next.st = S_IDLE;
    endcase
    // waitrequest kept as its own flop so the output needs no gate
    r_next.wreq = ~r_next.wait_n;
  end

  // ======================================================
  // state register; system reset also resets the flash [RL18]
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r_reg <= '{st: S_RST, cnt: 8'(FPC_RST_CYC), step: 2'h0, seq: 1'b0,
                 addr: '0, wdata: 16'h0000, rdata: 16'h0000, pcfg: FPC_PCFG_RESET,
                 ctrl: 9'h000, rb_sync: 2'b00, busy: 1'b1, rd: 32'h0, wait_n: 1'b0, wreq: 1'b1,
                 fa: '0, fd: 16'h0000, fdoe: 1'b0, cs: 3'h7, oe_n: 1'b1,
                 we_n: 1'b1, rp_n: 1'b0};
    end else begin
      r_reg <= r_next;
    end
  end

  // ======================================================
  // outputs straight from flip-flops
  assign avs_readdata_out        = r_reg.rd;
  assign avs_waitrequest_out     = r_reg.wreq;
  assign flash_addr_out          = r_reg.fa;
  assign flash_data_out          = r_reg.fd;
  assign flash_data_oe_out       = r_reg.fdoe;
  assign chip_selects_out        = r_reg.cs;
  assign flash_oe_n_out          = r_reg.oe_n;
  assign flash_we_n_out          = r_reg.we_n;
  assign powerdown_reset_n_out   = r_reg.rp_n;
  assign program_voltage_pin_out = r_reg.ctrl[FPC_CTRL_PROGRAM_VOLTAGE_PIN_BIT];  // [RL10]

  // ======================================================
  // checks
  sequence s_cfg_setup;
    r_reg.st == S_WE && r_reg.fd == FPC_SETCFG_SETUP && r_reg.seq;
  endsequence

  AST_SETUP_ADDR: assert property (@(posedge clk_in) disable iff (rst_in) // [RL2]
    s_cfg_setup |-> flash_addr_out[15:0] == r_reg.pcfg)
    else $error("config value not on address");
  AST_RESERVED: assert property (@(posedge clk_in) disable iff (rst_in) // [RL5]
    (r_reg.pcfg & 16'hdfff) == 16'h0000)
    else $error("reserved config bits set");
  AST_WE_RISE_CS: assert property (@(posedge clk_in) disable iff (rst_in) // [RL12]
    $rose(flash_we_n_out) |-> chip_selects_out == 3'h0)
    else $error("chip select dropped before we rise");
  AST_NO_OE_WE: assert property (@(posedge clk_in) disable iff (rst_in) // [RL11]
    !(flash_oe_n_out == 1'b0 && flash_we_n_out == 1'b0))
    else $error("oe and we low together");
  AST_RST_DESEL: assert property (@(posedge clk_in) disable iff (rst_in) // [RL16]
    !powerdown_reset_n_out |-> flash_we_n_out && flash_oe_n_out)
    else $error("access during flash reset");
  AST_REC_WAIT: assert property (@(posedge clk_in) disable iff (rst_in) // [RL17]
    $rose(powerdown_reset_n_out) |-> flash_we_n_out [*4])
    else $error("command too soon after reset");
  AST_RST_DEFAULT: assert property (@(posedge clk_in) disable iff (rst_in) // [RL19]
    $rose(powerdown_reset_n_out) |-> r_reg.pcfg == FPC_PCFG_RESET)
    else $error("config shadow not default");
  AST_DRIVE_ONLY_WRITE: assert property (@(posedge clk_in) disable iff (rst_in) // [RL7]
    flash_data_oe_out |-> flash_oe_n_out)
    else $error("bus contention");

  // confirm write of an eight-word set has just been latched
  sequence s_cfg_conf_done;
    $rose(flash_we_n_out) && r_reg.seq && r_reg.fd == FPC_SETCFG_CONF &&
      r_reg.pcfg[FPC_PAGE_LEN_BIT];
  endsequence

  // clear status written while the device is selected
  sequence s_clr_write;
    !flash_we_n_out && flash_data_out == FPC_CLR_STATUS && chip_selects_out == 3'h0;
  endsequence

  AST_CLR_AFTER_SET: assert property (@(posedge clk_in) disable iff (rst_in) // [RL6]
    s_cfg_conf_done |-> ##[1:8] s_clr_write)
    else $error("clear status missing after eight-word set");

endmodule // fpc_host

// ===== fpc_flash_model.sv
// behavioural model of the parallel nor flash behind the host controller
`timescale 1ns/100ps
module fpc_flash_model (
  input  wire logic [23:0] addr_in,
  input  wire logic [15:0] data_in,
  input  wire logic [2:0]  cs_in,
  input  wire logic        oe_n_in,
  input  wire logic        we_n_in,
  input  wire logic        rp_n_in,
  input  wire logic        program_voltage_pin_in,
  output logic      [15:0] data_out,
  output logic             rb_out
);
  logic [15:0] mem [16];
  logic [15:0] pcfg;
  logic [15:0] last_cmd;
  logic [15:0] prev;
  logic        sel;
  initial foreach (mem[i]) mem[i] = 16'hffff;
  // ======================================================
  // select, outputs drive the inverted word when not selected or oe high
  assign sel = (cs_in == 3'h0) && rp_n_in;
  assign rb_out = 1'b1; // engine never busy, so nothing left to run on deselect
  assign data_out = (sel && !oe_n_in) ? mem[addr_in[3:0]] : ~mem[addr_in[3:0]];
  // ======================================================
  // command front end: latched on we rising edge, no own address
  always @(posedge we_n_in or negedge rp_n_in) begin
    if (!rp_n_in) begin
      pcfg <= 16'h0000;
      prev <= 16'h00ff;
    end else if (sel) begin
      last_cmd <= data_in;
      prev <= (prev inside {16'h0060, 16'h0040, 16'h0020}) ? 16'h00ff : data_in;
      if (prev == 16'h0060 && data_in == 16'h0004)
        pcfg <= addr_in[15:0];
      if (prev == 16'h0040 && program_voltage_pin_in)
        mem[addr_in[3:0]] <= mem[addr_in[3:0]] & data_in;
      if (prev == 16'h0020 && data_in == 16'h00d0 && program_voltage_pin_in)
        foreach (mem[i]) mem[i] <= 16'hffff;
    end
  end
endmodule // fpc_flash_model

// ===== tb.sv
// self-checking testbench for the flash page-config host controller
`timescale 1ns/100ps
module tb;
  import fpc_pkg::*;
  logic        clk_in, rst_in, rd, wr, wreq, doe, oe_n, we_n, rp_n, program_voltage_pin, rb;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, r;
  logic [23:0] fa;
  logic [15:0] fdo, mdo, dq;
  logic [2:0]  cs;
  int          err_count = 0;
  int          num_checks = 0;
  assign dq = doe ? fdo : mdo; // shared data wire
  fpc_host DUT (.clk_in(clk_in), .rst_in(rst_in), .avs_address_in(adr), .avs_read_in(rd),
    .avs_write_in(wr), .avs_writedata_in(wdat), .avs_readdata_out(rdat),
    .avs_waitrequest_out(wreq), .flash_addr_out(fa), .flash_data_in(dq),
    .flash_data_out(fdo), .flash_data_oe_out(doe), .chip_selects_out(cs),
    .flash_oe_n_out(oe_n), .flash_we_n_out(we_n), .powerdown_reset_n_out(rp_n),
    .program_voltage_pin_out(program_voltage_pin), .ready_busy_output_in(rb));
  fpc_flash_model M (.addr_in(fa), .data_in(dq), .cs_in(cs), .oe_n_in(oe_n),
    .we_n_in(we_n), .rp_n_in(rp_n), .program_voltage_pin_in(program_voltage_pin), .data_out(mdo), .rb_out(rb));
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // ======================================================
  // reporting
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // ======================================================
  // avalon access, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_in);
    adr <= a;
    wdat <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (wreq !== 1'b0 && n < 200);
    r = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 200) begin
      err_count++;
      print_verdict();
    end
  endtask
  task automatic idle();
    int n;
    n = 0;
    do begin
      av(1'b0, FPC_STAT_OFS, 32'h0);
      n++;
    end while (r[0] !== 1'b0 && n < 50);
    if (n >= 50) begin
      err_count++;
      print_verdict();
    end
  endtask
  // one flash bus write, v drives the program voltage pin
  task automatic fw(input logic [23:0] a, input logic [15:0] d, input logic v);
    av(1'b1, FPC_ADDR_OFS, {8'h0, a});
    av(1'b1, FPC_WDATA_OFS, {16'h0, d});
    av(1'b1, FPC_CTRL_OFS, {23'h0, v, 5'h0, FPC_OP_WRITE});
    idle();
  endtask
  // array read of word a through the controller
  task automatic frd(input logic [23:0] a);
    fw(a, FPC_READ_ARRAY, 1'b0);
    av(1'b1, FPC_CTRL_OFS, {29'h0, FPC_OP_READ});
    idle();
    av(1'b0, FPC_RDATA_OFS, 32'h0);
  endtask
  // ======================================================
  // test sequence
  initial begin
    rst_in = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = 4'h0;
    wdat = 32'h0;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    idle();
    chk(r, 32'h2);
    av(1'b0, FPC_PCFG_OFS, 32'h0);
    chk(r, 32'h0);
    chk({16'h0, M.pcfg}, 32'h0);
    chk({29'h0, cs}, 32'h7);
    $display("test reset done");
    av(1'b1, FPC_WDATA_OFS, 32'h2000);
    av(1'b1, FPC_CTRL_OFS, {29'h0, FPC_OP_SETCFG});
    idle();
    chk({16'h0, M.pcfg}, 32'h2000);
    chk({16'h0, M.last_cmd}, 32'h50);
    av(1'b0, FPC_PCFG_OFS, 32'h0);
    chk(r, 32'h2000);
    $display("test page config done");
    fw(24'h5, 16'h0040, 1'b1);
    fw(24'h5, 16'h00f0, 1'b1);
    fw(24'h5, 16'h0040, 1'b1);
    fw(24'h5, 16'h0ff0, 1'b1);
    frd(24'h5);
    chk(r, 32'h00f0);
    fw(24'h3, 16'h0020, 1'b1);
    fw(24'h3, 16'h00d0, 1'b1);
    frd(24'h5);
    chk(r, 32'hffff);
    fw(24'h5, 16'h0040, 1'b0);
    fw(24'h5, 16'h0000, 1'b0);
    frd(24'h5);
    chk(r, 32'hffff);
    $display("test program erase done");
    av(1'b1, FPC_CTRL_OFS, {29'h0, FPC_OP_RESET});
    idle();
    chk({16'h0, M.pcfg}, 32'h0);
    av(1'b0, FPC_PCFG_OFS, 32'h0);
    chk(r, 32'h0);
    fw(24'h2000, FPC_SETCFG_SETUP, 1'b0);
    fw(24'h2000, 16'h0001, 1'b0);
    chk({16'h0, M.pcfg}, 32'h0);
    av(1'b0, 4'hf, 32'h0);
    chk(r, 32'h0);
    av(1'b1, 4'hf, 32'h1234);
    av(1'b0, FPC_ADDR_OFS, 32'h0);
    chk(r, 32'h2000);
    av(1'b1, FPC_CTRL_OFS, 32'h0);
    av(1'b0, FPC_STAT_OFS, 32'h0);
    chk(r, 32'h2);
    chk({29'h0, cs}, 32'h7);
    $display("test reset and refusal done");
    print_verdict();
  end
endmodule // tb
